// ==== pkg/port_pm_runtime_pkg.sv ====
package port_pm_runtime_pkg;

  ////////////////////////////////////////////////////////////////////////
  // structure and timing
  localparam int NUM_PORTS   = 4;
  localparam int NUM_INTR    = 8;
  // ports 1 and 2 speak USB 3.0, ports 3 and 4 USB 2.0
  localparam logic [3:0] USB3_PORT_MASK = 4'h3;

  localparam int CLK_PERIOD_NS  = 5;
  localparam int UFRAME_TIME_NS = 125000;
  localparam int UFRAME_CYCLES  = UFRAME_TIME_NS / CLK_PERIOD_NS;
  localparam int MOD_TICK_NS    = 250;
  localparam int MOD_TICK_CYCLES = MOD_TICK_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////
  // address map
  typedef logic [11:0] addr_type;
  localparam addr_type OP_PM_BASE    = 12'h404;
  localparam addr_type OP_LINK_BASE  = 12'h408;
  localparam addr_type PORT_STRIDE   = 12'h010;
  localparam addr_type RT_UFRAME     = 12'h000;
  localparam addr_type RT_INTR_BASE  = 12'h020;
  localparam addr_type RT_MOD_BASE   = 12'h024;
  localparam addr_type INTR_STRIDE   = 12'h020;
  localparam logic     SPACE_OPER    = 1'h0;
  localparam logic     SPACE_RUNTIME = 1'h1;

  localparam logic [15:0] MOD_INTERVAL_RST = 16'h0fa0;
  localparam logic [15:0] MOD_COUNT_RST    = 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // register layouts, msb first
  typedef struct packed {
    logic [14:0] rsvd;
    logic        force_link_accept;
    logic [7:0]  u2_idle_timeout;
    logic [7:0]  u1_idle_timeout;
  } usb3_pm_reg_type;

  typedef struct packed {
    logic [3:0]  test_mode_sel;
    logic [11:0] rsvd;
    logic [7:0]  lpm_target_slot;
    logic [3:0]  resume_drive_duration;
    logic        remote_wake_allow;
    logic [2:0]  lpm_result_status;
  } usb2_pm_reg_type;

  typedef struct packed {
    logic [15:0] rsvd;
    logic [15:0] link_error_count;
  } link_info_reg_type;

  typedef struct packed {
    logic [17:0] rsvd;
    logic [13:0] frame_tick_index;
  } uframe_reg_type;

  typedef struct packed {
    logic [29:0] rsvd;
    logic        irq_enable;
    logic        irq_pending;
  } intr_ctrl_reg_type;

  typedef struct packed {
    logic [15:0] moderation_countdown;
    logic [15:0] moderation_interval;
  } intr_mod_reg_type;

  ////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        space;
    addr_type    addr;
    logic [31:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
  } reg_rsp_type;

  typedef struct packed {
    logic [2:0]  lpm_result_status;
    logic [15:0] link_error_count;
  } port_status_type;

  typedef struct packed {
    logic        force_link_accept;
    logic [7:0]  u2_idle_timeout;
    logic [7:0]  u1_idle_timeout;
    logic [3:0]  test_mode_sel;
    logic [7:0]  lpm_target_slot;
    logic [3:0]  resume_drive_duration;
    logic        remote_wake_allow;
  } port_ctrl_type;

  typedef struct packed {
    logic        irq_enable;
    logic        irq_pending;
    logic        irq_request;
    logic [15:0] moderation_interval;
    logic [15:0] moderation_countdown;
  } intr_state_type;

endpackage

// ==== rtl/port_pm_runtime_regs.sv ====
`timescale 1ns/1ps

// Contract
// - one pm register per port, 404h+10h*(n-1)
// - usb3 pm: force accept, u2, u1 timeouts
// - u1/u2 timeouts survive ordinary reset
// - usb2 pm: test, slot, resume, wake, status
// - link error count at 408h, usb2 zero
// - reserved bits ignore writes, read zero
// - runtime map: index, gap, eight sets
// - 14-bit index counts every 125 us
// - interrupter enable bit, pending cleared on access
// - moderation interval, default 0fa0h, and counter, default 0
module port_pm_runtime_regs
  import port_pm_runtime_pkg::*;
#(
  parameter int UFRAME_LEN = UFRAME_CYCLES
) (
  input  wire logic                            clk,
  input  wire logic                            sys_rst,
  input  wire logic                            global_reset,
  input  wire reg_req_type                     reg_req,
  output reg_rsp_type                          reg_rsp,
  input  wire port_status_type [NUM_PORTS-1:0] port_status,
  output port_ctrl_type [NUM_PORTS-1:0]        port_ctrl,
  input  wire logic [NUM_INTR-1:0]             irq_event,
  output logic [NUM_INTR-1:0]                  irq_request
);

  // whole block state in one record; one register stage keeps outputs glitch free
  typedef struct packed {
    port_ctrl_type [NUM_PORTS-1:0] ports;
    intr_state_type [NUM_INTR-1:0] intr;
    logic [23:0]                   uframe_cnt;
    logic [13:0]                   frame_tick_index;
    logic [7:0]                    mod_presc;
    reg_rsp_type                   rsp;
  } state_type;

  ////////////////////////////////////////////////////////////////////////
  // address arithmetic stays 12 bits; a larger port count would alias
  function automatic addr_type pm_addr(input int p);
    pm_addr = addr_type'(OP_PM_BASE + PORT_STRIDE * addr_type'(p));
  endfunction

  function automatic addr_type link_addr(input int p);
    link_addr = addr_type'(OP_LINK_BASE + PORT_STRIDE * addr_type'(p));
  endfunction

  function automatic addr_type intr_addr(input addr_type base, input int i);
    intr_addr = addr_type'(base + INTR_STRIDE * addr_type'(i));
  endfunction

  // sticky timeouts are patched back by the caller on an ordinary reset
  function automatic state_type reset_state();
    state_type s;
    s = '0;
    for (int i = 0; i < NUM_INTR; i++) begin
      s.intr[i].moderation_interval  = MOD_INTERVAL_RST;
      s.intr[i].moderation_countdown = MOD_COUNT_RST;
    end
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  state_type st_ff;
  state_type nxt_st;

  always_comb begin
    usb3_pm_reg_type   r3;
    usb2_pm_reg_type   r2;
    link_info_reg_type li;
    uframe_reg_type    uf;
    intr_ctrl_reg_type ic;
    intr_mod_reg_type  im;
    logic              mod_tick;
    r3 = '0;
    r2 = '0;
    li = '0;
    uf = '0;
    ic = '0;
    im = '0;
    mod_tick = 1'b0;
    nxt_st = st_ff;
    nxt_st.rsp = '0;

    // microframe index, wraps at 14 bits
    // a long run simply wraps; software tracks the wrap itself
    if (st_ff.uframe_cnt == 24'(UFRAME_LEN - 1)) begin
      nxt_st.uframe_cnt       = '0;
      nxt_st.frame_tick_index = st_ff.frame_tick_index + 14'h0001;
    end else begin
      nxt_st.uframe_cnt = st_ff.uframe_cnt + 24'h00_0001;
    end

    // one shared 250 ns prescaler for every moderation countdown
    // trade-off: one counter instead of eight, so the first tick may come early
    mod_tick = (st_ff.mod_presc == 8'(MOD_TICK_CYCLES - 1));
    nxt_st.mod_presc = mod_tick ? 8'h00 : st_ff.mod_presc + 8'h01;
    for (int i = 0; i < NUM_INTR; i++) begin
      if (mod_tick && st_ff.intr[i].moderation_countdown != 16'h0000) begin
        nxt_st.intr[i].moderation_countdown = st_ff.intr[i].moderation_countdown - 16'h0001;
      end
    end

    // register access, answered one cycle later
    if (reg_req.valid) begin
      nxt_st.rsp.valid = 1'b1;
      if (reg_req.space == SPACE_OPER) begin
        for (int p = 0; p < NUM_PORTS; p++) begin
          if (reg_req.addr == pm_addr(p)) begin
            // usb3 and usb2 ports share the offset; the port mask picks the layout
            if (USB3_PORT_MASK[p]) begin
              r3.force_link_accept = st_ff.ports[p].force_link_accept;
              r3.u2_idle_timeout   = st_ff.ports[p].u2_idle_timeout;
              r3.u1_idle_timeout   = st_ff.ports[p].u1_idle_timeout;
              nxt_st.rsp.rdata     = r3;
              if (reg_req.write) begin
                r3 = usb3_pm_reg_type'(reg_req.wdata);
                nxt_st.ports[p].force_link_accept = r3.force_link_accept;
                nxt_st.ports[p].u2_idle_timeout   = r3.u2_idle_timeout;
                nxt_st.ports[p].u1_idle_timeout   = r3.u1_idle_timeout;
              end
            end else begin
              r2.test_mode_sel         = st_ff.ports[p].test_mode_sel;
              r2.lpm_target_slot       = st_ff.ports[p].lpm_target_slot;
              r2.resume_drive_duration = st_ff.ports[p].resume_drive_duration;
              r2.remote_wake_allow     = st_ff.ports[p].remote_wake_allow;
              // l1 status is live from the port side, never stored here
              r2.lpm_result_status     = port_status[p].lpm_result_status;
              nxt_st.rsp.rdata         = r2;
              if (reg_req.write) begin
                r2 = usb2_pm_reg_type'(reg_req.wdata);
                nxt_st.ports[p].test_mode_sel         = r2.test_mode_sel;
                nxt_st.ports[p].lpm_target_slot       = r2.lpm_target_slot;
                nxt_st.ports[p].resume_drive_duration = r2.resume_drive_duration;
                nxt_st.ports[p].remote_wake_allow     = r2.remote_wake_allow;
              end
            end
          end else if (reg_req.addr == link_addr(p)) begin
            // usb2 ports leave li at zero
            if (USB3_PORT_MASK[p]) begin
              li.link_error_count = port_status[p].link_error_count;
            end
            nxt_st.rsp.rdata = li;
          end
        end
      end else begin
        if (reg_req.addr == RT_UFRAME) begin
          uf.frame_tick_index = st_ff.frame_tick_index;
          nxt_st.rsp.rdata    = uf;
        end
        // each interrupter owns a 20h block: control at +0, moderation at +4
        for (int i = 0; i < NUM_INTR; i++) begin
          if (reg_req.addr == intr_addr(RT_INTR_BASE, i)) begin
            ic.irq_enable  = st_ff.intr[i].irq_enable;
            ic.irq_pending = st_ff.intr[i].irq_pending;
            nxt_st.rsp.rdata = ic;
            // any access clears pending; a same-cycle event re-sets it below
            nxt_st.intr[i].irq_pending = 1'b0;
            if (reg_req.write) begin
              ic = intr_ctrl_reg_type'(reg_req.wdata);
              nxt_st.intr[i].irq_enable = ic.irq_enable;
            end
          end else if (reg_req.addr == intr_addr(RT_MOD_BASE, i)) begin
            im.moderation_countdown = st_ff.intr[i].moderation_countdown;
            im.moderation_interval  = st_ff.intr[i].moderation_interval;
            nxt_st.rsp.rdata = im;
            if (reg_req.write) begin
              im = intr_mod_reg_type'(reg_req.wdata);
              // a software countdown write overrides this cycle's decrement
              nxt_st.intr[i].moderation_countdown = im.moderation_countdown;
              nxt_st.intr[i].moderation_interval  = im.moderation_interval;
            end
          end
        end
      end
    end

    // request generation; an event wins over a same-cycle clear
    // a request start reloads the countdown even over a same-cycle software write
    for (int i = 0; i < NUM_INTR; i++) begin
      if (irq_event[i]) begin
        nxt_st.intr[i].irq_pending = 1'b1;
      end
      if (!(st_ff.intr[i].irq_pending && st_ff.intr[i].irq_enable)) begin
        nxt_st.intr[i].irq_request = 1'b0;
      end else if (!st_ff.intr[i].irq_request && st_ff.intr[i].moderation_countdown == 16'h0000) begin
        nxt_st.intr[i].irq_request          = 1'b1;
        nxt_st.intr[i].moderation_countdown = st_ff.intr[i].moderation_interval;
      end
    end

    // global reset loads every reset default (interval 0fa0h, rest zero); ordinary reset spares sticky timeouts
    // limitation: global reset must be raised once at power-up, else the timeouts start unknown
    if (global_reset) begin
      nxt_st = reset_state();
    end else if (sys_rst) begin
      nxt_st = reset_state();
      for (int p = 0; p < NUM_PORTS; p++) begin
        nxt_st.ports[p].u1_idle_timeout = st_ff.ports[p].u1_idle_timeout;
        nxt_st.ports[p].u2_idle_timeout = st_ff.ports[p].u2_idle_timeout;
      end
    end
  end

  // reset is folded into the next-state logic, so the register needs no reset branch
  always_ff @(posedge clk) begin
    st_ff <= nxt_st;
  end

  ////////////////////////////////////////////////////////////////////////
  // every data output comes straight from the state register
  assign reg_rsp   = st_ff.rsp;
  assign port_ctrl = st_ff.ports;

  always_comb begin
    for (int i = 0; i < NUM_INTR; i++) begin
      irq_request[i] = st_ff.intr[i].irq_request;
    end
  end

endmodule

// ==== test/port_pm_runtime_props.sv ====
`timescale 1ns/1ps
module port_pm_runtime_props
  import port_pm_runtime_pkg::*;
(
  input wire logic                            clk,
  input wire logic                            sys_rst,
  input wire logic                            global_reset,
  input wire reg_req_type                     reg_req,
  input wire reg_rsp_type                     reg_rsp,
  input wire port_status_type [NUM_PORTS-1:0] port_status,
  input wire port_ctrl_type [NUM_PORTS-1:0]   port_ctrl,
  input wire logic [NUM_INTR-1:0]             irq_event,
  input wire logic [NUM_INTR-1:0]             irq_request
);
  wire logic     rd = reg_req.valid & ~reg_req.write;
  wire logic     wr = reg_req.valid & reg_req.write;
  wire logic     op = reg_req.space == SPACE_OPER;
  wire addr_type a  = reg_req.addr;
  default clocking @(posedge clk); endclocking
  // both resets drop requests, so neither side is judged across them
  default disable iff (sys_rst | global_reset);
  //////////////////////////////////////////////////////////////////////
  a_rsp_follows: assert property (reg_req.valid |=> reg_rsp.valid) else $error("no answer");
  a_rsp_only: assert property (!reg_req.valid |=> !reg_rsp.valid) else $error("stray answer");
  a_u1_write: assert property (wr && op && a == 12'h404 |=>
    port_ctrl[0].u1_idle_timeout == $past(reg_req.wdata[7:0])) else $error("u1 not written");
  a_test_write: assert property (wr && op && a == 12'h434 |=>
    port_ctrl[3].test_mode_sel == $past(reg_req.wdata[31:28])) else $error("test sel not written");
  a_link_count: assert property (rd && op && a == 12'h408 |=>
    reg_rsp.rdata == {16'h0, $past(port_status[0].link_error_count)}) else $error("bad count");
  a_usb2_link: assert property (rd && op && a == 12'h428 |=> reg_rsp.rdata == 32'h0) else $error("usb2 link");
  a_gap_zero: assert property (rd && !op && a >= 12'h004 && a <= 12'h01f |=>
    reg_rsp.rdata == 32'h0) else $error("gap not zero");
  a_index_rsvd: assert property (rd && !op && a == 12'h000 |=> reg_rsp.rdata[31:14] == 18'h0) else $error("idx");
  a_ctrl_rsvd: assert property (rd && !op && a == 12'h020 |=> reg_rsp.rdata[31:2] == 30'h0) else $error("ctl");
  a_irq_drop: assert property (wr && !op && a == 12'h020 && !reg_req.wdata[1] |=> ##1
    !irq_request[0]) else $error("irq kept");
  c_irq: cover property (irq_request[0]);
  c_rt_write: cover property (wr && !op);
  c_usb2_link: cover property (rd && op && a == 12'h428);
  c_irq_last: cover property (irq_request[7]);
endmodule
bind port_pm_runtime_regs port_pm_runtime_props chk_u (.clk(clk), .sys_rst(sys_rst), .global_reset(global_reset),
  .reg_req(reg_req), .reg_rsp(reg_rsp), .port_status(port_status), .port_ctrl(port_ctrl),
  .irq_event(irq_event), .irq_request(irq_request));

// ==== test/xhci_port_pm_runtime_regs_tb_top.sv ====
`timescale 1ns/1ps
module xhci_port_pm_runtime_regs_tb_top
  import port_pm_runtime_pkg::*;
;
  localparam int UL = 20;
  logic                            clk = 0, sys_rst = 1, global_reset = 1;
  reg_req_type                     req = '0;
  reg_rsp_type                     rsp;
  port_status_type [NUM_PORTS-1:0] pst = '0;
  port_ctrl_type [NUM_PORTS-1:0]   pct;
  logic [NUM_INTR-1:0]             ev = '0, irq;
  logic [31:0]                     r, q;
  int                              fails = 0, checked = 0;
  always #2.5 clk = ~clk;
  port_pm_runtime_regs #(.UFRAME_LEN(UL)) dut_u (.clk(clk), .sys_rst(sys_rst), .global_reset(global_reset),
    .reg_req(req), .reg_rsp(rsp), .port_status(pst), .port_ctrl(pct), .irq_event(ev), .irq_request(irq));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // one request, answer taken at the falling edge that follows it
  task automatic acc(input logic w, sp, input addr_type a, input logic [31:0] d);
    int n;
    n = 0;
    @(negedge clk);
    req = '{1'b1, w, sp, a, d};
    @(negedge clk);
    req.valid = 1'b0;
    while (rsp.valid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    r = rsp.rdata;
    if (n == 4) chk(32'h0, 32'h1);
  endtask
  task automatic rdc(input logic sp, input addr_type a, input logic [31:0] e);
    acc(1'b0, sp, a, 32'h0);
    chk(r, e);
  endtask
  task automatic wirq(input logic e, input int m);
    int n;
    n = 0;
    while (irq[0] !== e && n < m) begin
      @(negedge clk);
      n++;
    end
    chk(irq[0], e);
  endtask
  task automatic pulse;
    ev[0] = 1'b1;
    @(negedge clk);
    ev[0] = 1'b0;
  endtask
  task automatic conclude;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(negedge clk);
    sys_rst = 0;
    global_reset = 0;
    for (int i = 0; i < NUM_INTR; i++) begin
      rdc(1'b1, addr_type'(RT_MOD_BASE + INTR_STRIDE * i), 32'h0000_0fa0);
      rdc(1'b1, addr_type'(RT_INTR_BASE + INTR_STRIDE * i), 32'h0000_0000);
    end
    for (int p = 0; p < NUM_PORTS; p++) rdc(1'b0, addr_type'(OP_PM_BASE + PORT_STRIDE * p), 32'h0);
    rdc(1'b0, 12'h000, 32'h0);
    rdc(1'b1, 12'h010, 32'h0);
    $display("reset values done");
    pst[2].lpm_result_status = 3'h5;
    acc(1'b1, 1'b0, 12'h404, 32'hffff_ffff);
    rdc(1'b0, 12'h404, 32'h0001_ffff);
    chk({pct[0].force_link_accept, pct[0].u2_idle_timeout, pct[0].u1_idle_timeout}, 32'h0001_ffff);
    acc(1'b1, 1'b0, 12'h414, 32'h0000_1234);
    rdc(1'b0, 12'h414, 32'h0000_1234);
    acc(1'b1, 1'b0, 12'h424, 32'hffff_ffff);
    rdc(1'b0, 12'h424, 32'hf000_fffd);
    chk({pct[2].test_mode_sel, pct[2].lpm_target_slot, pct[2].resume_drive_duration, pct[2].remote_wake_allow},
        32'h0001_ffff);
    acc(1'b1, 1'b0, 12'h434, 32'h5000_0000);
    pst[0].link_error_count = 16'hbeef;
    pst[2].link_error_count = 16'h5555;
    acc(1'b1, 1'b0, 12'h408, 32'hffff_ffff);
    rdc(1'b0, 12'h408, 32'h0000_beef);
    rdc(1'b0, 12'h428, 32'h0);
    $display("port registers done");
    acc(1'b1, 1'b0, 12'h404, 32'h0001_a55a);
    sys_rst = 1;
    repeat (2) @(negedge clk);
    sys_rst = 0;
    rdc(1'b0, 12'h404, 32'h0000_a55a);
    global_reset = 1;
    repeat (2) @(negedge clk);
    global_reset = 0;
    rdc(1'b0, 12'h404, 32'h0);
    $display("sticky done");
    acc(1'b0, 1'b1, RT_UFRAME, 32'h0);
    q = r;
    repeat (UL - 2) @(negedge clk);
    rdc(1'b1, RT_UFRAME, {18'h0, q[13:0] + 14'h1});
    for (int i = 0; i < NUM_INTR; i++) begin
      acc(1'b1, 1'b1, addr_type'(RT_MOD_BASE + INTR_STRIDE * i), 32'h0000_0100 + i);
      rdc(1'b1, addr_type'(RT_MOD_BASE + INTR_STRIDE * i), 32'h0000_0100 + i);
    end
    $display("runtime map done");
    acc(1'b1, 1'b1, 12'h024, 32'h0000_0002);
    acc(1'b1, 1'b1, 12'h020, 32'h0000_0002);
    pulse();
    wirq(1'b1, 4);
    rdc(1'b1, 12'h020, 32'h0000_0003);
    wirq(1'b0, 3);
    rdc(1'b1, 12'h020, 32'h0000_0002);
    // countdown of two ticks keeps the next request back for at least 50 cycles
    pulse();
    repeat (3) @(negedge clk);
    chk(irq[0], 1'b0);
    wirq(1'b1, 120);
    acc(1'b1, 1'b1, 12'h020, 32'h0);
    wirq(1'b0, 3);
    acc(1'b1, 1'b1, 12'h100, 32'h0000_0002);
    ev[7] = 1'b1;
    @(negedge clk);
    ev[7] = 1'b0;
    @(negedge clk);
    chk(irq, 8'h80);
    rdc(1'b1, 12'h100, 32'h0000_0003);
    @(negedge clk);
    chk(irq, 8'h00);
    $display("interrupter done");
    conclude();
  end
  initial begin
    #20000;
    fails++;
    conclude();
  end
endmodule
